// [rsrm_defs.vh]
// register map, port selects and state codes of the repeater statistics bank
`ifndef RSRM_DEFS_VH
`define RSRM_DEFS_VH
// host port selects on ADDR
`define RSRM_A_DATA 2'h0
`define RSRM_A_BANK 2'h1
`define RSRM_A_REG 2'h2
`define RSRM_A_STAT 2'h3
// banks
`define RSRM_BK_REP 5'h00
`define RSRM_BK_FLAG 5'h01
`define RSRM_BK_EN 5'h02
`define RSRM_BK_TP0 5'h10
`define RSRM_BK_TP7 5'h17
`define RSRM_BK_AUI 5'h1f
// repeater bank registers
`define RSRM_R_MATCH 5'h0a
`define RSRM_R_TOTOCT 5'h0c
`define RSRM_R_TXCOL 5'h0d
`define RSRM_R_CFG 5'h10
`define RSRM_R_VER 5'h1c
`define RSRM_R_SET 5'h1e
`define RSRM_R_GET 5'h1f
// flag and enable banks
`define RSRM_R_FLAG_LAST 5'h09
`define RSRM_R_EN_LAST 5'h07
`define RSRM_R_FLAG_RSVD 4
`define RSRM_NFLAG 10
// port banks
`define RSRM_R_CNT_LAST 5'h0c
`define RSRM_R_LSA 5'h0e
`define RSRM_AUI_IDX 4'h8
`define RSRM_REP_PORT 4'hf
`define RSRM_CNT_TOTOCT 4'h0
`define RSRM_CNT_TXCOL 4'h1
// reset values
`define RSRM_CFG_RST 8'h00
`define RSRM_EN_RST 8'h00
// aui status get requests are turned into the non-clearing form
`define RSRM_AUI_GET_MASK 8'hfc
`define RSRM_AUI_GET_BASE 8'h88
`define RSRM_AUI_GET_SAFE 8'h89
// management port timing, clocks per serial bit
`define RSRM_BIT_CYC 4
// management port states
`define RSRM_S_IDLE 2'h0
`define RSRM_S_TX 2'h1
`define RSRM_S_RX 2'h2
`endif

// [rsrm_top.v]
// repeater statistics register bank with host port and management serial port
`include "rsrm_defs.vh"
`timescale 1ns/1ns
`default_nettype none
module rsrm_top #(
	parameter BIT_CYC = `RSRM_BIT_CYC,
	// identity value is arbitrary
	parameter [7:0] VERSION = 8'h5a
) (
	// clock and reset
	input wire CLOCK,
	input wire NRST,
	// host port
	input wire SEL_N,
	input wire RD_N,
	input wire WR_N,
	input wire [1:0] ADDR,
	input wire [7:0] DIN,
	output reg [7:0] DOUT,
	output wire DOE,
	output wire RDY,
	output wire IRQ,
	// status change set pulses, one byte per flag register
	input wire [79:0] FLAG_SET,
	// counter events
	input wire EVT_STB,
	input wire [3:0] EVT_PORT,
	input wire [3:0] EVT_CNT,
	input wire [15:0] EVT_ADD,
	// last source address updates
	input wire SA_STB,
	input wire [3:0] SA_PORT,
	input wire [47:0] SA_VAL,
	// management serial port
	output wire MGMT_SCK,
	output wire MGMT_EN,
	output wire MGMT_TXD,
	input wire MGMT_RXD
);
	reg rst1_r;
	reg rst_n;
	always @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			rst1_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst1_r <= 1'b1;
			rst_n <= rst1_r;
		end
	end

	// host cycle tracking
	reg cyc_r;
	reg done_r;
	reg [7:0] bank_r;
	reg [7:0] reg_r;
	reg [2:0] idx_r;
	reg [47:0] shadow_r;
	reg [1:0] st_r;
	wire strobe = !SEL_N && (!RD_N || !WR_N);
	wire rd = !RD_N;
	wire [4:0] bk = bank_r[4:0];
	wire [4:0] rg = reg_r[4:0];
	wire is_data = (ADDR == `RSRM_A_DATA);
	wire mgmt_reg = (bk == `RSRM_BK_REP) &&
		((rg == `RSRM_R_SET) || (rg == `RSRM_R_GET));
	// accesses to the serial windows wait for the port to go idle
	wire hold = is_data && mgmt_reg && (st_r != `RSRM_S_IDLE);
	wire act = cyc_r && strobe && !done_r && !hold;
	wire dwr = act && !rd && is_data;
	wire drd = act && rd && is_data;
	assign RDY = !(strobe && !done_r);
	assign DOE = !SEL_N && !RD_N;

	always @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			cyc_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			cyc_r <= strobe;
			done_r <= strobe && (done_r || act);
		end
	end

	// port bank to storage index
	wire is_tp = (bk >= `RSRM_BK_TP0) && (bk <= `RSRM_BK_TP7);
	wire is_port = is_tp || (bk == `RSRM_BK_AUI);
	wire [3:0] pidx = is_tp ? {1'b0, bk[2:0]} : `RSRM_AUI_IDX;

	// change flags and enables
	reg [7:0] flag_r [0:`RSRM_NFLAG-1];
	reg [7:0] en_r [0:7];
	wire [7:0] pend;
	genvar gi;
	generate
		for (gi = 0; gi < `RSRM_NFLAG; gi = gi + 1) begin : g_flag
			if (gi == `RSRM_R_FLAG_RSVD) begin : g_rsvd
				// clocked zero: an input-free comb block never runs
				always @(posedge CLOCK or negedge rst_n) begin
					if (!rst_n)
						flag_r[gi] <= 8'h00;
					else
						flag_r[gi] <= 8'h00;
				end
			end else begin : g_live
				wire clr = drd && (bk == `RSRM_BK_FLAG) &&
					(rg == gi);
				// a set arriving with the read-clear is kept
				always @(posedge CLOCK or negedge rst_n) begin
					if (!rst_n)
						flag_r[gi] <= 8'h00;
					else
						flag_r[gi] <= (clr ? 8'h00 : flag_r[gi]) |
							FLAG_SET[gi*8 +: 8];
				end
			end
		end
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_en
			if (gi == `RSRM_R_FLAG_RSVD) begin : g_rsvd
				always @(posedge CLOCK or negedge rst_n) begin
					if (!rst_n)
						en_r[gi] <= 8'h00;
					else
						en_r[gi] <= 8'h00;
				end
			end else begin : g_live
				wire wen = dwr && (bk == `RSRM_BK_EN) && (rg == gi);
				always @(posedge CLOCK or negedge rst_n) begin
					if (!rst_n)
						en_r[gi] <= `RSRM_EN_RST;
					else if (wen)
						en_r[gi] <= DIN;
				end
			end
			assign pend[gi] = |(flag_r[gi] & en_r[gi]);
		end
	endgenerate
	assign IRQ = |pend;

	// counters, indexed by {port, counter}
	reg [31:0] cnt_mem [0:143];
	reg [47:0] lsa_mem [0:8];
	reg [31:0] tot_oct_r;
	reg [31:0] tx_col_r;
	reg [47:0] match_r;
	reg [7:0] cfg_r;
	reg [7:0] get_data_r;
	wire [7:0] ev_i = {EVT_PORT, EVT_CNT};
	wire ev_port = EVT_STB && (EVT_PORT <= `RSRM_AUI_IDX) &&
		(EVT_CNT <= `RSRM_R_CNT_LAST);
	// port counters hold no reset; software reads deltas after power-up
	always @(posedge CLOCK) begin
		if (ev_port)
			cnt_mem[ev_i] <= cnt_mem[ev_i] +
				{16'h0000, EVT_ADD};
	end
	always @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			tot_oct_r <= 32'h00000000;
			tx_col_r <= 32'h00000000;
		end else if (EVT_STB && (EVT_PORT == `RSRM_REP_PORT)) begin
			if (EVT_CNT == `RSRM_CNT_TOTOCT)
				tot_oct_r <= tot_oct_r + {16'h0000, EVT_ADD};
			else if (EVT_CNT == `RSRM_CNT_TXCOL)
				tx_col_r <= tx_col_r + {16'h0000, EVT_ADD};
		end
	end

	// last source address: host byte write yields to a live update
	wire lsa_wr = dwr && is_port && (rg == `RSRM_R_LSA) &&
		(idx_r < 3'h6);
	reg [47:0] lsa_w;
	always @* begin
		lsa_w = lsa_mem[pidx];
		lsa_w[idx_r*8 +: 8] = DIN;
	end
	always @(posedge CLOCK) begin
		if (SA_STB && (SA_PORT <= `RSRM_AUI_IDX))
			lsa_mem[SA_PORT] <= SA_VAL;
		else if (lsa_wr)
			lsa_mem[pidx] <= lsa_w;
	end

	// repeater bank writable registers
	wire rep_wr = dwr && (bk == `RSRM_BK_REP);
	always @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			match_r <= 48'h000000000000;
			cfg_r <= `RSRM_CFG_RST;
		end else if (rep_wr) begin
			if (rg == `RSRM_R_MATCH && idx_r < 3'h6)
				match_r[idx_r*8 +: 8] <= DIN;
			else if (rg == `RSRM_R_CFG)
				cfg_r <= DIN;
		end
	end

	// read word selection
	reg [47:0] sel_w;
	always @* begin
		sel_w = 48'h000000000000;
		if (bk == `RSRM_BK_REP) begin
			if (rg == `RSRM_R_MATCH)
				sel_w = match_r;
			else if (rg == `RSRM_R_TOTOCT)
				sel_w = {16'h0000, tot_oct_r};
			else if (rg == `RSRM_R_TXCOL)
				sel_w = {16'h0000, tx_col_r};
			else if (rg == `RSRM_R_CFG)
				sel_w = {40'h0000000000, cfg_r};
			else if (rg == `RSRM_R_VER)
				sel_w = {40'h0000000000, VERSION};
			else if (rg == `RSRM_R_GET)
				sel_w = {40'h0000000000, get_data_r};
		end else if (bk == `RSRM_BK_FLAG) begin
			if (rg <= `RSRM_R_FLAG_LAST)
				sel_w = {40'h0000000000, flag_r[rg[3:0]]};
		end else if (bk == `RSRM_BK_EN) begin
			if (rg <= `RSRM_R_EN_LAST)
				sel_w = {40'h0000000000, en_r[rg[2:0]]};
		end else if (is_port) begin
			if (rg <= `RSRM_R_CNT_LAST)
				sel_w = {16'h0000, cnt_mem[{pidx, rg[3:0]}]};
			else if (rg == `RSRM_R_LSA)
				sel_w = lsa_mem[pidx];
		end
	end

	// first byte snapshots the whole word so later bytes do not tear
	wire [47:0] src_w = (idx_r == 3'h0) ? sel_w : shadow_r;
	reg [7:0] rbyte;
	always @* begin
		case (idx_r)
		3'h0: rbyte = src_w[7:0];
		3'h1: rbyte = src_w[15:8];
		3'h2: rbyte = src_w[23:16];
		3'h3: rbyte = src_w[31:24];
		3'h4: rbyte = src_w[39:32];
		3'h5: rbyte = src_w[47:40];
		default: rbyte = 8'h00;
		endcase
	end

	wire busy = (st_r != `RSRM_S_IDLE);
	always @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			bank_r <= 8'h00;
			reg_r <= 8'h00;
			idx_r <= 3'h0;
			shadow_r <= 48'h000000000000;
			DOUT <= 8'h00;
		end else if (act) begin
			if (ADDR == `RSRM_A_BANK) begin
				if (rd)
					DOUT <= bank_r;
				else
					bank_r <= DIN;
				idx_r <= 3'h0;
			end else if (ADDR == `RSRM_A_REG) begin
				if (rd)
					DOUT <= reg_r;
				else
					reg_r <= DIN;
				idx_r <= 3'h0;
			end else if (ADDR == `RSRM_A_STAT) begin
				if (rd)
					DOUT <= {6'h00, busy, IRQ};
			end else begin
				if (rd) begin
					DOUT <= rbyte;
					if (idx_r == 3'h0)
						shadow_r <= sel_w;
				end
				idx_r <= idx_r + 3'h1;
			end
		end
	end

	// management serial port
	reg [7:0] sh_r;
	reg [2:0] bit_r;
	reg [15:0] ph_r;
	reg get_r;
	localparam [15:0] PH_END = BIT_CYC - 1;
	localparam [15:0] PH_MID = BIT_CYC / 2;
	wire ph_last = (ph_r == PH_END);
	wire set_wr = rep_wr && (rg == `RSRM_R_SET);
	wire get_wr = rep_wr && (rg == `RSRM_R_GET);
	wire aui_get = ((DIN & `RSRM_AUI_GET_MASK) == `RSRM_AUI_GET_BASE);
	always @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= `RSRM_S_IDLE;
			sh_r <= 8'h00;
			bit_r <= 3'h0;
			ph_r <= 16'h0000;
			get_r <= 1'b0;
			get_data_r <= 8'h00;
		end else begin
			case (st_r)
			`RSRM_S_IDLE: begin
				ph_r <= 16'h0000;
				bit_r <= 3'h0;
				if (set_wr) begin
					sh_r <= DIN;
					get_r <= 1'b0;
					st_r <= `RSRM_S_TX;
				end else if (get_wr) begin
					sh_r <= aui_get ? `RSRM_AUI_GET_SAFE : DIN;
					get_r <= 1'b1;
					st_r <= `RSRM_S_TX;
				end
			end
			`RSRM_S_TX: begin
				ph_r <= ph_last ? 16'h0000 : ph_r + 16'h0001;
				if (ph_last) begin
					sh_r <= {sh_r[6:0], 1'b0};
					bit_r <= bit_r + 3'h1;
					if (bit_r == 3'h7)
						st_r <= get_r ? `RSRM_S_RX : `RSRM_S_IDLE;
				end
			end
			`RSRM_S_RX: begin
				ph_r <= ph_last ? 16'h0000 : ph_r + 16'h0001;
				if (ph_r == PH_MID)
					sh_r <= {sh_r[6:0], MGMT_RXD};
				if (ph_last) begin
					bit_r <= bit_r + 3'h1;
					if (bit_r == 3'h7) begin
						get_data_r <= sh_r;
						st_r <= `RSRM_S_IDLE;
					end
				end
			end
			default: st_r <= `RSRM_S_IDLE;
			endcase
		end
	end
	assign MGMT_EN = busy;
	assign MGMT_SCK = busy && (ph_r >= PH_MID);
	assign MGMT_TXD = (st_r == `RSRM_S_TX) && sh_r[7];
endmodule
`default_nettype wire

// [rsrm_props.sv]
// checker for the host and serial ports of the statistics bank
`timescale 1ns/1ns
`default_nettype none
module rsrm_props #(parameter BIT_CYC = 4) (
	input wire CLOCK, NRST, SEL_N, RD_N, WR_N,
	input wire [1:0] ADDR,
	input wire [7:0] DOUT,
	input wire DOE, RDY, IRQ,
	input wire [79:0] FLAG_SET,
	input wire MGMT_SCK, MGMT_EN, MGMT_TXD
);
	localparam int LO = 8 * BIT_CYC;
	localparam int HI = 16 * BIT_CYC;
	wire stb = !SEL_N && (!RD_N || !WR_N);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!NRST);
	doe_match_a: assert property (DOE == (!SEL_N && !RD_N))
		else $error("bus enable wrong");
	rdy_drop_a: assert property ($rose(stb) |-> !RDY)
		else $error("ready not low");
	rdy_stand_a: assert property (RDY && stb |=>
		!stb || RDY && $stable(DOUT)) else $error("ready or data moved");
	stat_quick_a: assert property ($rose(stb) && ADDR == 2'h3 |->
		##[1:4] RDY) else $error("status read slow");
	irq_steady_a: assert property (!stb && FLAG_SET == 80'h0 |=>
		$stable(IRQ)) else $error("irq moved");
	ser_min_a: assert property ($rose(MGMT_EN) |-> MGMT_EN[*8])
		else $error("transfer short");
	ser_max_a: assert property ($rose(MGMT_EN) |-> ##[LO:HI] !MGMT_EN)
		else $error("transfer long");
	sck_idle_a: assert property (!MGMT_EN |-> !MGMT_SCK)
		else $error("clock outside frame");
	txd_hold_a: assert property ($rose(MGMT_SCK) |-> $stable(MGMT_TXD))
		else $error("data moved at clock");
endmodule
bind rsrm_top rsrm_props #(.BIT_CYC(BIT_CYC)) rsrm_props_i (.CLOCK, .NRST,
	.SEL_N, .RD_N, .WR_N, .ADDR, .DOUT, .DOE, .RDY, .IRQ, .FLAG_SET,
	.MGMT_SCK, .MGMT_EN, .MGMT_TXD);
`default_nettype wire

// [rsrm_chip_model.sv]
// repeater chip seen from its management serial port
`timescale 1ns/1ns
`default_nettype none
module rsrm_chip_model (
	input wire logic clk,
	input wire logic sck,
	input wire logic en,
	input wire logic txd,
	input wire logic [7:0] reply,
	output logic rxd,
	output logic [7:0] cmd
);
	logic sck_q = 1'b0;
	logic [4:0] nb = 5'h00;
	initial rxd = 1'b0;
	initial cmd = 8'h00;
	always @(posedge clk) begin
		sck_q <= sck;
		if (!en) begin
			nb <= 5'h00;
			// released line toggles so a stale bit is never read
			rxd <= ~rxd;
		end else if (sck && !sck_q) begin
			if (nb < 5'h08)
				cmd <= {cmd[6:0], txd};
			nb <= nb + 5'h01;
		end else if (!sck && sck_q && nb > 5'h07 && nb < 5'h10) begin
			rxd <= reply[4'hf - nb[3:0]];
		end
	end
endmodule
`default_nettype wire

// [tb_repeater_stats_register_map.sv]
// self-checking bench for the repeater statistics register bank
`timescale 1ns/1ns
`default_nettype none
module tb_repeater_stats_register_map;
	logic CLOCK = 1'b0, NRST = 1'b0, SEL_N = 1'b1, RD_N = 1'b1;
	logic WR_N = 1'b1, SA_STB = 1'b0;
	logic [1:0] ADDR = 2'h0;
	logic [3:0] SA_PORT = 4'h0;
	logic [7:0] DIN = 8'h00, rq, rep = 8'h00, x, g, b;
	logic [7:0] e [0:7];
	logic [79:0] FLAG_SET = 80'h0;
	logic [47:0] SA_VAL = 48'h0;
	logic [95:0] f;
	logic [31:0] seed = 32'h3a0a;
	logic EVT_STB = 1'b0;
	logic [3:0] EVT_PORT = 4'h0, EVT_CNT = 4'h0;
	logic [15:0] EVT_ADD = 16'h0;
	logic [31:0] t, s;
	wire [7:0] DOUT, cmd;
	wire RDY, IRQ, SCK, MEN, TXD, RXD;
	integer err_total = 0, total_checks = 0, cyc = 0, i, j, n, p;
	rsrm_top rsrm_top_i (.CLOCK, .NRST, .SEL_N, .RD_N, .WR_N, .ADDR,
		.DIN, .DOUT, .DOE(), .RDY, .IRQ, .FLAG_SET, .EVT_STB,
		.EVT_PORT, .EVT_CNT, .EVT_ADD, .SA_STB,
		.SA_PORT, .SA_VAL, .MGMT_SCK(SCK), .MGMT_EN(MEN),
		.MGMT_TXD(TXD), .MGMT_RXD(RXD));
	rsrm_chip_model rsrm_chip_model_i (.clk(CLOCK), .sck(SCK), .en(MEN),
		.txd(TXD), .reply(rep), .rxd(RXD), .cmd(cmd));
	always #20 CLOCK = ~CLOCK;
	always @(posedge CLOCK) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			complete_run;
		end
	end
	function automatic [31:0] rnd;
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		rnd = seed;
	endfunction
	function automatic [7:0] sent(input [7:0] c);
		sent = ((c & 8'hfc) == 8'h88) ? 8'h89 : c;
	endfunction
	task chk(input [7:0] got, input [7:0] want);
		total_checks = total_checks + 1;
		if (got !== want) begin
			err_total = err_total + 1;
			$display("BAD %0t got %h want %h", $time, got, want);
		end
	endtask
	// strobe held until ready is seen high at an edge
	task acc(input [1:0] a, input wr, input [7:0] d);
		@(posedge CLOCK);
		SEL_N <= 1'b0;
		ADDR <= a;
		DIN <= d;
		RD_N <= wr;
		WR_N <= !wr;
		n = 0;
		@(posedge CLOCK);
		while (RDY !== 1'b1 && n < 300) begin
			@(posedge CLOCK);
			n = n + 1;
		end
		if (n >= 300) err_total = err_total + 1;
		rq = DOUT;
		SEL_N <= 1'b1;
		RD_N <= 1'b1;
		WR_N <= 1'b1;
	endtask
	task sel(input [7:0] bk, input [7:0] r);
		acc(2'h1, 1'b1, bk);
		acc(2'h2, 1'b1, r);
	endtask
	task rd1(input [7:0] bk, input [7:0] r);
		sel(bk, r);
		acc(2'h0, 1'b0, 8'h00);
	endtask
	task chk6(input [7:0] bk, input [47:0] w);
		integer k;
		sel(bk, 8'h0e);
		for (k = 0; k < 6; k = k + 1) begin
			acc(2'h0, 1'b0, 8'h00);
			chk(rq, w[8*k +: 8]);
		end
	endtask
	task complete_run;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge CLOCK);
		NRST <= 1'b1;
		repeat (3) @(posedge CLOCK);
		acc(2'h3, 1'b0, 8'h00);
		chk(rq, 8'h00);
		for (i = 0; i < 8; i = i + 1) begin
			e[i] = (i == 0) ? 8'hff : 8'(rnd());
			if (i != 4) begin
				x = 8'(rnd());
				sel({x[7:5], 5'h02}, i[7:0]);
				acc(2'h0, 1'b1, e[i]);
				rd1(8'h02, i[7:0]);
				chk(rq, e[i]);
			end
		end
		f = {rnd(), rnd(), rnd()};
		FLAG_SET <= f[79:0];
		@(posedge CLOCK);
		FLAG_SET <= 80'h0;
		x = 8'h00;
		for (i = 0; i < 8; i = i + 1)
			if (i != 4) x = x | (f[8*i +: 8] & e[i]);
		@(posedge CLOCK);
		chk({7'h0, IRQ}, {7'h0, |x});
		acc(2'h3, 1'b0, 8'h00);
		chk(rq, {7'h0, |x});
		for (i = 0; i < 10; i = i + 1)
			if (i != 4) begin
				rd1(8'h01, i[7:0]);
				chk(rq, f[8*i +: 8]);
			end
		chk({7'h0, IRQ}, 8'h00);
		for (i = 0; i < 3; i = i + 1) begin
			x = 8'(rnd());
			sel(8'h00, 8'h1e);
			acc(2'h0, 1'b1, x);
			acc(2'h3, 1'b0, 8'h00);
			chk(rq, 8'h02);
			g = (i == 0) ? 8'h8a : 8'(rnd());
			rep <= 8'(rnd());
			sel(8'h00, 8'h1f);
			acc(2'h0, 1'b1, g);
			chk(cmd, x);
			rd1(8'h00, 8'h1f);
			chk(rq, rep);
			chk(cmd, sent(g));
		end
		for (j = 0; j < 2; j = j + 1) begin
			p = (j == 0) ? 8 : rnd() % 8;
			b = (p == 8) ? 8'h1f : 8'h10 + p[7:0];
			f = {rnd(), rnd(), rnd()};
			SA_PORT <= p[3:0];
			SA_VAL <= f[47:0];
			SA_STB <= 1'b1;
			@(posedge CLOCK);
			SA_STB <= 1'b0;
			chk6(b, f[47:0]);
			sel(b, 8'h0e);
			for (i = 0; i < 6; i = i + 1)
				acc(2'h0, 1'b1, f[48+8*i +: 8]);
			chk6(b, f[95:48]);
		end
		// repeater-level totals: two events summed, read as 4 bytes
		for (j = 0; j < 2; j = j + 1) begin
			t = rnd();
			s = {16'h0000, t[15:0]} + {16'h0000, t[31:16]};
			EVT_PORT <= 4'hf;
			EVT_CNT <= j[3:0];
			EVT_ADD <= t[15:0];
			EVT_STB <= 1'b1;
			@(posedge CLOCK);
			EVT_ADD <= t[31:16];
			@(posedge CLOCK);
			EVT_STB <= 1'b0;
			sel(8'h00, (j == 0) ? 8'h0c : 8'h0d);
			for (i = 0; i < 4; i = i + 1) begin
				acc(2'h0, 1'b0, 8'h00);
				chk(rq, s[8*i +: 8]);
			end
		end
		complete_run;
	end
endmodule
`default_nettype wire
